// *** rx_descriptor_dma.sv ***
// receive descriptor dma engine: walks buffer chains, stores usb data
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`default_nettype none
module rx_descriptor_dma
  import rx_dma_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [31:0] MEM_ADDR,
  output logic [3:0] MEM_SEL,
  output logic [31:0] MEM_WDATA,
  input wire logic [31:0] MEM_RDATA,
  input wire logic MEM_ACK,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_LAST,
  input wire logic RX_ZERO,
  output logic RX_READY
);
  // ************************************************************
  // submodules
  // ************************************************************
  dma_mem_if mi();
  dma_reg_if ri();

  rx_dma_mem_port u_mem (
    .clk(CLK_SYS),
    .rst(RESET),
    .mem_req(MEM_REQ),
    .mem_we(MEM_WE),
    .mem_addr(MEM_ADDR),
    .mem_sel(MEM_SEL),
    .mem_wdata(MEM_WDATA),
    .mem_rdata(MEM_RDATA),
    .mem_ack(MEM_ACK),
    .m(mi.port)
  );

  rx_dma_wb_regs u_regs (
    .clk(CLK_SYS),
    .rst(RESET),
    .wb_cyc(WB_CYC),
    .wb_stb(WB_STB),
    .wb_we(WB_WE),
    .wb_adr(WB_ADR),
    .wb_sel(WB_SEL),
    .wb_dat_i(WB_DAT_I),
    .wb_dat_o(WB_DAT_O),
    .wb_ack(WB_ACK),
    .r(ri.regs)
  );

  // ************************************************************
  // engine state
  // ************************************************************
  state_e state, next_state;
  logic [31:0] desc, next_desc, first_desc, next_first_desc;
  logic [31:0] link, next_link, buf_ptr, next_buf_ptr;
  logic [31:0] len_word, next_len_word, flag_word, next_flag_word;
  logic [31:0] wr_ptr, next_wr_ptr, comp, next_comp;
  logic [15:0] room, next_room, count, next_count;
  logic [15:0] pkt_len, next_pkt_len, skip, next_skip;
  logic [7:0] byte_q, next_byte_q;
  logic [1:0] widx, next_widx;
  logic first, next_first, last, next_last, zero, next_zero;
  logic in_pkt, next_in_pkt, waiting, next_waiting;
  logic rdy, next_rdy, done_p, next_done_p, starve_p, next_starve_p;
  logic req, next_req, we, next_we;
  logic [31:0] addr, next_addr, wdata, next_wdata;
  logic [3:0] sel, next_sel;

  assign mi.req = req;
  assign mi.we = we;
  assign mi.addr = addr;
  assign mi.sel = sel;
  assign mi.wdata = wdata;
  assign ri.busy = state != S_IDLE;
  assign ri.cur_desc = desc;
  assign ri.comp_ptr = comp;
  assign ri.pkt_done = done_p;
  assign ri.starved = starve_p;
  assign RX_READY = rdy;

  always_comb
  begin
    next_state = state;
    {next_desc, next_first_desc, next_link, next_buf_ptr} =
      {desc, first_desc, link, buf_ptr};
    {next_len_word, next_flag_word, next_wr_ptr, next_comp} =
      {len_word, flag_word, wr_ptr, comp};
    {next_room, next_count, next_pkt_len, next_skip} =
      {room, count, pkt_len, skip};
    {next_byte_q, next_widx, next_first, next_last, next_zero} =
      {byte_q, widx, first, last, zero};
    {next_in_pkt, next_waiting} = {in_pkt, waiting};
    {next_rdy, next_done_p, next_starve_p, next_req} = 4'h0;
    {next_we, next_addr, next_wdata, next_sel} = {we, addr, wdata, sel};
    // a memory-facing state issues one request, then waits for done
    if (!waiting && !req && state inside {S_FETCH, S_PUTB, S_CLOSE_LEN,
        S_CLOSE_FLAG, S_FIRST_FLAG})
    begin
      next_req = 1'b1;
      next_waiting = 1'b1;
      next_sel = 4'hf;
      next_we = 1'b1;
    end
    case (state)
      S_IDLE:
      begin
        if (ri.go && ri.enable && ri.head != 32'h0000_0000)
        begin
          next_desc = {ri.head[31:4], 4'h0};
          next_widx = 2'h0;
          next_in_pkt = 1'b0;
          next_state = S_FETCH;
        end
      end
      S_FETCH:
      begin
        next_we = 1'b0;
        next_addr = desc + {28'h0, widx, 2'b00};
        if (mi.done)
        begin
          next_waiting = 1'b0;
          case (widx)
            2'h0: next_link = mi.rdata;
            2'h1: next_buf_ptr = mi.rdata;
            2'h2: next_len_word = mi.rdata;
            default: next_flag_word = mi.rdata;
          endcase
          next_widx = widx + 2'h1;
          if (widx == LAST_WORD)
            next_state = S_CHECK;
        end
      end
      S_CHECK:
      begin
        next_count = 16'h0000;
        next_last = 1'b0;
        if (!in_pkt)
        begin
          // ownership is only looked at on a packet's first buffer
          if (!flag_word[OWN_BIT])
          begin
            next_starve_p = 1'b1;
            next_state = S_IDLE;
          end
          else
          begin
            next_first = 1'b1;
            next_first_desc = desc;
            next_skip = ri.offset;
            next_wr_ptr = buf_ptr + {16'h0000, ri.offset};
            next_room = len_word[15:0] - ri.offset;
            next_pkt_len = 16'h0000;
            next_zero = 1'b0;
            next_in_pkt = 1'b1;
            next_state = S_RECV;
          end
        end
        else
        begin
          next_first = 1'b0;
          next_skip = 16'h0000;
          next_wr_ptr = buf_ptr;
          next_room = len_word[15:0];
          next_state = S_RECV;
        end
        // a continuation buffer with no room is closed without taking data
        if (in_pkt && len_word[15:0] == 16'h0000)
          next_state = S_CLOSE_LEN;
      end
      S_RECV:
      begin
        next_rdy = !(RX_VALID && rdy);
        if (RX_VALID && rdy)
        begin
          next_byte_q = RX_DATA;
          next_last = RX_LAST || RX_ZERO;
          if (RX_ZERO)
          begin
            next_zero = 1'b1;
            next_state = S_CLOSE_LEN;
          end
          else
            next_state = S_PUTB;
        end
      end
      S_PUTB:
      begin
        // one byte lane per write keeps any alignment legal
        next_addr = {wr_ptr[31:2], 2'b00};
        next_sel = 4'h1 << wr_ptr[1:0];
        next_wdata = {4{byte_q}};
        if (mi.done)
        begin
          next_waiting = 1'b0;
          next_wr_ptr = wr_ptr + 32'h0000_0001;
          next_count = count + 16'h0001;
          next_pkt_len = pkt_len + 16'h0001;
          if (last || count + 16'h0001 == room)
            next_state = S_CLOSE_LEN;
          else
            next_state = S_RECV;
        end
      end
      S_CLOSE_LEN:
      begin
        next_addr = desc + DESC_LEN_OFS;
        next_wdata = {skip, count};
        if (mi.done)
        begin
          next_waiting = 1'b0;
          next_state = S_CLOSE_FLAG;
        end
      end
      S_CLOSE_FLAG:
      begin
        next_addr = desc + DESC_FLAG_OFS;
        next_wdata = 32'h0000_0000;
        next_wdata[PACKET_FIRST_FLAG_BIT] = first;
        next_wdata[PACKET_LAST_FLAG_BIT] = last;
        // the first buffer's owner stays set until the whole packet is stored
        next_wdata[OWN_BIT] = first && !last;
        next_wdata[QUEUE_END_FLAG_BIT] = last && link == 32'h0;
        next_wdata[ZERO_BYTE_BIT] = first && zero;
        next_wdata[15:0] = first ? pkt_len : 16'h0000;
        if (mi.done)
        begin
          next_waiting = 1'b0;
          next_state = (last && !first) ? S_FIRST_FLAG : S_NEXT;
        end
      end
      S_FIRST_FLAG:
      begin
        next_addr = first_desc + DESC_FLAG_OFS;
        next_wdata = 32'h0000_0000;
        next_wdata[PACKET_FIRST_FLAG_BIT] = 1'b1;
        next_wdata[ZERO_BYTE_BIT] = zero;
        next_wdata[15:0] = pkt_len;
        if (mi.done)
        begin
          next_waiting = 1'b0;
          next_state = S_NEXT;
        end
      end
      S_NEXT:
      begin
        if (last)
        begin
          next_in_pkt = 1'b0;
          next_comp = desc;
          next_done_p = 1'b1;
        end
        if (link == 32'h0000_0000)
        begin
          next_starve_p = !last;
          next_state = S_IDLE;
        end
        else
        begin
          next_desc = {link[31:4], 4'h0};
          next_widx = 2'h0;
          next_state = S_FETCH;
        end
      end
      default: next_state = S_IDLE;
    endcase
    if (next_state == S_RECV && state != S_RECV)
      next_rdy = 1'b1;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      state <= S_IDLE;
      comp <= COMP_RST;
      {desc, first_desc, link, buf_ptr} <= 128'h0;
      {len_word, flag_word, wr_ptr, addr, wdata} <= 160'h0;
      {room, count, pkt_len, skip} <= 64'h0;
      {byte_q, widx, sel} <= 14'h0;
      {first, last, zero, in_pkt, waiting, rdy} <= 6'h0;
      {done_p, starve_p, req, we} <= 4'h0;
    end
    else
    begin
      state <= next_state;
      {desc, first_desc, link, buf_ptr} <=
        {next_desc, next_first_desc, next_link, next_buf_ptr};
      {len_word, flag_word, wr_ptr, comp} <=
        {next_len_word, next_flag_word, next_wr_ptr, next_comp};
      {room, count, pkt_len, skip} <=
        {next_room, next_count, next_pkt_len, next_skip};
      {byte_q, widx, first, last, zero} <=
        {next_byte_q, next_widx, next_first, next_last, next_zero};
      {in_pkt, waiting, rdy, done_p, starve_p, req} <= {next_in_pkt,
        next_waiting, next_rdy, next_done_p, next_starve_p, next_req};
      {we, addr, wdata, sel} <= {next_we, next_addr, next_wdata, next_sel};
    end
  end
endmodule // rx_descriptor_dma
`default_nettype wire

// *** rx_descriptor_dma_props.sv ***
// assertion checker watching the receive descriptor dma ports
`default_nettype none
module rx_descriptor_dma_props
(
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_ACK,
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [3:0] MEM_SEL,
  input wire logic [31:0] MEM_WDATA,
  input wire logic [31:0] MEM_RDATA,
  input wire logic MEM_ACK,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_ZERO,
  input wire logic RX_READY
);
  // ************************************************************
  // helper state
  // ************************************************************
  logic [31:0] last_rd;
  logic [31:0] cur_link;
  logic [7:0] taken;
  logic flag_wr;
  assign flag_wr = MEM_REQ && MEM_WE && MEM_SEL == 4'hf
    && MEM_ADDR[3:0] == 4'hc;
  always_ff @(posedge CLK_SYS)
  begin
    if (MEM_REQ && MEM_ACK && !MEM_WE)
    begin
      last_rd <= MEM_ADDR;
      if (MEM_ADDR[3:0] == 4'h0)
        cur_link <= MEM_RDATA;
    end
    if (RX_VALID && RX_READY)
      taken <= RX_DATA;
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // ************************************************************
  // properties
  // ************************************************************
  a_wb_answer: assert property (WB_CYC && WB_STB && !WB_ACK |=> WB_ACK)
    else $error("wishbone ack missing");
  a_wb_pulse: assert property (WB_ACK |=> !WB_ACK)
    else $error("wishbone ack held");
  a_mem_hold: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ
    && $stable(MEM_ADDR) && $stable(MEM_WE) && $stable(MEM_SEL)
    && $stable(MEM_WDATA)) else $error("memory request changed");
  a_mem_gap: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ [*2])
    else $error("memory request too soon");
  a_desc_read: assert property (MEM_REQ && !MEM_WE |->
    MEM_SEL == 4'hf && MEM_ADDR[1:0] == 2'h0)
    else $error("descriptor read misaligned");
  a_fetch_order: assert property ($rose(MEM_REQ) && !MEM_WE
    && MEM_ADDR[3:0] != 4'h0 |-> MEM_ADDR == last_rd + 32'h4)
    else $error("descriptor words out of order");
  a_byte_store: assert property (RX_VALID && RX_READY && !RX_ZERO
    |=> !RX_READY ##[0:8] (MEM_REQ && MEM_WE && MEM_SEL != 4'hf
    && MEM_WDATA[7:0] == taken)) else $error("byte not stored");
  a_own_done: assert property (flag_wr && MEM_WDATA[30]
    |-> !MEM_WDATA[29]) else $error("ownership left set");
  a_queue_end: assert property (flag_wr |->
    MEM_WDATA[28] == (MEM_WDATA[30] && cur_link == 32'h0))
    else $error("queue end flag wrong");
  a_reset_quiet: assert property (disable iff (1'b0) RESET
    |=> !MEM_REQ && !WB_ACK && !RX_READY) else $error("busy in reset");
  c_zero: cover property (flag_wr && MEM_WDATA[23]);
  c_qend: cover property (flag_wr && MEM_WDATA[28]);
  c_byte: cover property (RX_VALID && RX_READY);
endmodule // rx_descriptor_dma_props

bind rx_descriptor_dma rx_descriptor_dma_props u_props (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .WB_CYC(WB_CYC), .WB_STB(WB_STB),
  .WB_ACK(WB_ACK), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
  .MEM_ADDR(MEM_ADDR), .MEM_SEL(MEM_SEL), .MEM_WDATA(MEM_WDATA),
  .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .RX_VALID(RX_VALID),
  .RX_DATA(RX_DATA), .RX_ZERO(RX_ZERO), .RX_READY(RX_READY));
`default_nettype wire

// *** rx_descriptor_dma_tb.sv ***
// self-checking bench of the receive descriptor dma
`default_nettype none
module rx_descriptor_dma_tb;
  import rx_dma_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] DA = 32'h0000_0100;
  localparam logic [31:0] DB = 32'h0000_0110;
  localparam logic [31:0] BA = 32'h0000_0200;
  localparam logic [31:0] BB = 32'h0000_0280;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, wbwe = 1'b0, ack, mreq, mwe, mack;
  logic rv = 1'b0, rl = 1'b0, rz = 1'b0, rr;
  logic [7:0] adr = 8'h00, rxd = 8'h00;
  logic [3:0] sel = 4'hf, msel;
  logic [1:0] slow = 2'h0;
  logic [31:0] wdat = 32'h0, rdat, maddr, mwdata, mrdata;
  logic [7:0] pkt [0:63];
  int fails = 0;
  int check_count = 0;
  always #12.5 clk = ~clk;
  rx_descriptor_dma DUT (
    .CLK_SYS(clk), .RESET(rst), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(wbwe),
    .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK(ack), .MEM_REQ(mreq), .MEM_WE(mwe), .MEM_ADDR(maddr),
    .MEM_SEL(msel), .MEM_WDATA(mwdata), .MEM_RDATA(mrdata),
    .MEM_ACK(mack), .RX_VALID(rv), .RX_DATA(rxd), .RX_LAST(rl),
    .RX_ZERO(rz), .RX_READY(rr));
  rx_mem_model mem (.clk(clk), .req(mreq), .we(mwe), .addr(maddr),
    .sel(msel), .wdata(mwdata), .slow(slow), .rdata(mrdata), .ack(mack));
  // ************************************************************
  // helpers
  // ************************************************************
  task finish_test;
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", what, e, g);
      fails++;
    end
  endtask
  function automatic void pw(logic [31:0] a, logic [31:0] v);
    for (int i = 0; i < 4; i++)
      mem.mb[a + i] = v[8*i +: 8];
  endfunction
  function automatic logic [31:0] rw(logic [31:0] a);
    return {mem.mb[a + 3], mem.mb[a + 2], mem.mb[a + 1], mem.mb[a]};
  endfunction
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    wbwe <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
    begin
      fails++;
      finish_test();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task wait_status(input int b);
    logic [31:0] s;
    int n;
    n = 0;
    do
    begin
      wb(1'b0, REG_STATUS, 32'h0, s);
      n++;
    end
    while (s[b] !== 1'b1 && n < 200);
    chk("status bit", 32'h1, {31'h0, s[b]});
    if (s[b] !== 1'b1)
      finish_test();
    wb(1'b1, REG_STATUS, 32'h1 << b, s);
  endtask
  // n of zero sends a zero-length packet
  task send(input int n);
    int t;
    for (int i = 0; i < (n == 0 ? 1 : n); i++)
    begin
      rv <= 1'b1;
      rxd <= pkt[i];
      rl <= (n > 0 && i == n - 1);
      rz <= (n == 0);
      t = 0;
      do
      begin
        @(posedge clk);
        t++;
      end
      while (rr !== 1'b1 && t < 200);
      if (rr !== 1'b1)
      begin
        fails++;
        finish_test();
      end
    end
    rv <= 1'b0;
    rl <= 1'b0;
    rz <= 1'b0;
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    logic [31:0] q;
    int la, lb, off, room, n;
    void'($urandom(32'h7c182a2d));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, REG_CTRL, 32'h0, q);
    chk("ctrl reset", CTRL_RST, q);
    wb(1'b0, 8'h3c, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    wb(1'b1, REG_CTRL, 32'h1, q);
    // random split, exact fill, one byte over the first buffer
    for (int k = 0; k < 3; k++)
    begin
      la = 8 + $urandom % 8;
      lb = 4 + $urandom % 8;
      off = $urandom % 4;
      room = la - off;
      n = (k == 0) ? room + 1 + $urandom % lb : (k == 1) ? room + lb
        : room + 1;
      for (int i = 0; i < n; i++)
        pkt[i] = 8'($urandom);
      pw(DA, DB);
      pw(DA + 4, BA);
      pw(DA + 8, la);
      pw(DA + 12, 32'h2000_0000);
      pw(DB, 32'h0);
      pw(DB + 4, BB);
      pw(DB + 8, lb);
      pw(DB + 12, 32'h0);
      slow <= k[1:0];
      wb(1'b1, REG_OFFSET, off, q);
      wb(1'b1, REG_HEAD, DA, q);
      send(n);
      wait_status(ST_DONE_BIT);
      for (int i = 0; i < n; i++)
        chk("data", pkt[i],
          i < room ? mem.mb[BA + off + i] : mem.mb[BB + i - room]);
      chk("first len", {off[15:0], room[15:0]}, rw(DA + 8));
      chk("last len", n - room, rw(DB + 8));
      chk("first flags", 32'h8000_0000 | n, rw(DA + 12));
      chk("last flags", 32'h5000_0000, rw(DB + 12));
      wb(1'b0, REG_COMP, 32'h0, q);
      chk("completion", DB, q);
    end
    pw(DA, 32'h0);
    pw(DA + 8, 32'h0000_0001);
    pw(DA + 12, 32'h2000_0000);
    wb(1'b1, REG_HEAD, DA, q);
    send(0);
    wait_status(ST_DONE_BIT);
    chk("zero flags", 32'hd080_0000, rw(DA + 12));
    pw(DA + 12, 32'h0);
    wb(1'b1, REG_HEAD, DA, q);
    wait_status(ST_STARVED_BIT);
    chk("ready starved", 32'h0, {31'h0, rr});
    finish_test();
  end
endmodule // rx_descriptor_dma_tb
`default_nettype wire

// *** rx_dma_if.sv ***
// interfaces between the engine, its memory port and its register slave
`default_nettype none
interface dma_mem_if;
  logic req;
  logic we;
  logic [31:0] addr;
  logic [3:0] sel;
  logic [31:0] wdata;
  logic done;
  logic [31:0] rdata;
  modport engine(output req, we, addr, sel, wdata, input done, rdata);
  modport port(input req, we, addr, sel, wdata, output done, rdata);
endinterface

interface dma_reg_if;
  logic enable;
  logic go;
  logic [31:0] head;
  logic [15:0] offset;
  logic busy;
  logic [31:0] cur_desc;
  logic [31:0] comp_ptr;
  logic pkt_done;
  logic starved;
  modport regs(output enable, go, head, offset,
               input busy, cur_desc, comp_ptr, pkt_done, starved);
  modport engine(input enable, go, head, offset,
                 output busy, cur_desc, comp_ptr, pkt_done, starved);
endinterface
`default_nettype wire

// *** rx_dma_mem_port.sv ***
// system memory master: holds a request until acknowledged
`default_nettype none
module rx_dma_mem_port
  import rx_dma_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [3:0] mem_sel,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  dma_mem_if.port m
);
  logic next_req;
  logic next_done;
  logic [31:0] next_rdata;
  logic done;
  logic [31:0] rdata;

  assign m.done = done;
  assign m.rdata = rdata;

  always_comb
  begin
    next_req = mem_req;
    next_done = 1'b0;
    next_rdata = rdata;
    if (m.req)
      next_req = 1'b1;
    else if (mem_req && mem_ack)
    begin
      next_req = 1'b0;
      next_done = 1'b1;
      next_rdata = mem_rdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_sel <= 4'h0;
      mem_wdata <= 32'h0000_0000;
      done <= 1'b0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      mem_req <= next_req;
      done <= next_done;
      rdata <= next_rdata;
      if (m.req)
      begin
        mem_we <= m.we;
        mem_addr <= m.addr;
        mem_sel <= m.sel;
        mem_wdata <= m.wdata;
      end
    end
  end
endmodule // rx_dma_mem_port
`default_nettype wire

// *** rx_dma_pkg.sv ***
// constants, register map and state codes of the receive descriptor dma
`default_nettype none
package rx_dma_pkg;
  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_HEAD = 8'h04;
  localparam logic [7:0] REG_OFFSET = 8'h08;
  localparam logic [7:0] REG_COMP = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_STARVED_BIT = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] HEAD_RST = 32'h0000_0000;
  localparam logic [15:0] OFFSET_RST = 16'h0000;
  localparam logic [31:0] COMP_RST = 32'h0000_0000;
  // ************************************************************
  // descriptor layout
  // ************************************************************
  localparam logic [31:0] DESC_LINK_OFS = 32'h0000_0000;
  localparam logic [31:0] DESC_BUF_OFS = 32'h0000_0004;
  localparam logic [31:0] DESC_LEN_OFS = 32'h0000_0008;
  localparam logic [31:0] DESC_FLAG_OFS = 32'h0000_000c;
  localparam int PACKET_FIRST_FLAG_BIT = 31;
  localparam int PACKET_LAST_FLAG_BIT = 30;
  localparam int OWN_BIT = 29;
  localparam int QUEUE_END_FLAG_BIT = 28;
  localparam int ZERO_BYTE_BIT = 23;
  localparam int SKIP_LSB = 16;
  localparam logic [1:0] LAST_WORD = 2'h3;
  // ************************************************************
  // engine states
  // ************************************************************
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_FETCH = 4'b0001,
    S_CHECK = 4'b0010,
    S_RECV = 4'b0011,
    S_PUTB = 4'b0100,
    S_CLOSE_LEN = 4'b0101,
    S_CLOSE_FLAG = 4'b0110,
    S_FIRST_FLAG = 4'b0111,
    S_NEXT = 4'b1000
  } state_e;
endpackage
`default_nettype wire

// *** rx_dma_wb_regs.sv ***
// classic wishbone slave holding control and status of the engine
`default_nettype none
module rx_dma_wb_regs
  import rx_dma_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack,
  dma_reg_if.regs r
);
  function automatic logic [31:0] merge(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] sel);
    logic [31:0] v;
    v = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        v[8*i +: 8] = new_v[8*i +: 8];
    return v;
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_a);
    return adr[7:2] == reg_a[7:2];
  endfunction

  logic [31:0] ctrl, next_ctrl, head, next_head, next_dat;
  logic [15:0] offset, next_offset;
  logic done_f, next_done_f, starved_f, next_starved_f, go, next_go;
  logic next_ack, wr;
  logic [31:0] offset_word;

  assign r.enable = ctrl[CTRL_EN_BIT];
  assign r.head = head;
  assign r.offset = offset;
  assign r.go = go;

  always_comb
  begin
    next_ack = wb_cyc && wb_stb && !wb_ack;
    // writes land on the edge where the master sees ack
    wr = wb_cyc && wb_stb && wb_we && wb_ack;
    next_ctrl = (wr && hit(wb_adr, REG_CTRL)) ?
      merge(ctrl, wb_dat_i, wb_sel) : ctrl;
    next_head = (wr && hit(wb_adr, REG_HEAD)) ?
      merge(head, wb_dat_i, wb_sel) : head;
    // only the low half of the merged word is a real register
    offset_word = merge({16'h0000, offset}, wb_dat_i, wb_sel);
    next_offset = (wr && hit(wb_adr, REG_OFFSET)) ?
      offset_word[15:0] : offset;
    next_go = wr && hit(wb_adr, REG_HEAD);
    // hardware set wins over a write-one clear in the same cycle
    next_done_f = r.pkt_done || (done_f && !(wr &&
      hit(wb_adr, REG_STATUS) && wb_sel[0] && wb_dat_i[ST_DONE_BIT]));
    next_starved_f = r.starved || (starved_f && !(wr &&
      hit(wb_adr, REG_STATUS) && wb_sel[0] && wb_dat_i[ST_STARVED_BIT]));
    case (wb_adr[7:2])
      REG_CTRL[7:2]: next_dat = ctrl;
      REG_HEAD[7:2]: next_dat = r.cur_desc;
      REG_OFFSET[7:2]: next_dat = {16'h0000, offset};
      REG_COMP[7:2]: next_dat = r.comp_ptr;
      REG_STATUS[7:2]: next_dat = {29'h0, starved_f, done_f, r.busy};
      default: next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl <= CTRL_RST;
      head <= HEAD_RST;
      offset <= OFFSET_RST;
      go <= 1'b0;
      done_f <= 1'b0;
      starved_f <= 1'b0;
      wb_ack <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ctrl <= next_ctrl;
      head <= next_head;
      offset <= next_offset;
      go <= next_go;
      done_f <= next_done_f;
      starved_f <= next_starved_f;
      wb_ack <= next_ack;
      wb_dat_o <= next_dat;
    end
  end
endmodule // rx_dma_wb_regs
`default_nettype wire

// *** rx_mem_model.sv ***
// behavioural system memory answering the engine's requests
`default_nettype none
module rx_mem_model
(
  input wire logic clk,
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [3:0] sel,
  input wire logic [31:0] wdata,
  input wire logic [1:0] slow,
  output logic [31:0] rdata,
  output logic ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mb [0:4095];
  logic [1:0] cnt = 2'h0;
  logic [11:0] a;
  assign a = {addr[11:2], 2'b00};
  initial
  begin
    ack = 1'b0;
    rdata = 32'h0;
  end
  always @(posedge clk)
  begin
    if (req && ack && we)
      for (int i = 0; i < 4; i++)
        if (sel[i])
          mb[a + i] <= wdata[8*i +: 8];
    if (req && !ack && cnt >= slow)
    begin
      ack <= 1'b1;
      rdata <= {mb[a + 3], mb[a + 2], mb[a + 1], mb[a]};
    end
    else
    begin
      // data toggles between answers so stale reads never look valid
      ack <= 1'b0;
      rdata <= ~rdata;
    end
    cnt <= (req && !ack) ? cnt + 2'h1 : 2'h0;
  end
endmodule // rx_mem_model
`default_nettype wire
